//--- design/omc_comparator.sv
`default_nettype none
// Overview of operation
// - Four selectors route functions to outputs
// - Each output message reusable as signal source
// - Code 4: active above frequency threshold
// - Release below threshold minus switch-off delta
// - Delta above threshold: never released again
// - Threshold result is internal source 164
// - Code 5: frequency reached, source 163
// - Code 6: percentage reached, source 178
// - Tolerance band percent of span, clamped
// - Codes 100-194 give inverted function
module omc_comparator
  import omc_pkg::*;
(
  input  wire logic                 mclk_i,
  input  wire logic                 rst_i,
  input  wire logic [omc_pkg::FREQ_W-1:0] stator_freq_i,
  input  wire logic [omc_pkg::FREQ_W-1:0] ref_freq_i,
  input  wire logic [omc_pkg::FREQ_W-1:0] freq_max_i,
  input  wire logic [omc_pkg::FREQ_W-1:0] freq_min_i,
  input  wire logic [omc_pkg::FREQ_W-1:0] act_pct_i,
  input  wire logic [omc_pkg::FREQ_W-1:0] ref_pct_i,
  input  wire logic [omc_pkg::FREQ_W-1:0] pct_max_i,
  input  wire logic [omc_pkg::FREQ_W-1:0] pct_min_i,
  input  wire logic [omc_pkg::FREQ_W-1:0] thresh_i,
  input  wire logic [omc_pkg::FREQ_W-1:0] delta_i,
  input  wire logic [omc_pkg::TOL_W-1:0]  tol_i,
  input  wire logic [omc_pkg::SEL_W-1:0]  first_sel_i,
  input  wire logic [omc_pkg::SEL_W-1:0]  relay_sel_i,
  input  wire logic [omc_pkg::SEL_W-1:0]  terminal_sel_i,
  input  wire logic [omc_pkg::SEL_W-1:0]  multi_sel_i,
  input  wire logic [omc_pkg::SEL_W-1:0]  src_query_i,
  output logic                      src_value_o,
  output logic                      thresh_msg_o,
  output logic                      freq_ref_msg_o,
  output logic                      pct_ref_msg_o,
  output logic                      first_switch_output_o,
  output logic                      relay_switch_output_o,
  output logic                      terminal_switch_output_o,
  output logic                      multifunction_switch_output_o
);
  omc_msg_if msg ();

  ////////////////////////////////////////////////////////////////////////
  // Helper functions

  // Absolute difference of two values
  function automatic logic [FREQ_W-1:0] abs_diff(
    input logic [FREQ_W-1:0] a,
    input logic [FREQ_W-1:0] b);
    abs_diff = (a >= b) ? a - b : b - a;
  endfunction

  // Reached when |act-ref|*100% <= span*tol
  function automatic logic reached(
    input logic [FREQ_W-1:0] act,
    input logic [FREQ_W-1:0] refv,
    input logic [FREQ_W-1:0] hi,
    input logic [FREQ_W-1:0] lo,
    input logic [TOL_W-1:0]  tol);
    logic [FREQ_W-1:0] span;
    logic [PROD_W+FREQ_W-1:0] lhs;
    logic [PROD_W+FREQ_W-1:0] rhs;
    span = (hi >= lo) ? hi - lo : '0;
    // Both products sized wide first so the span term cannot wrap
    lhs  = (PROD_W+FREQ_W)'(abs_diff(act, refv)) * TOL_FULL_SCALE;
    rhs  = {{FREQ_W{1'b0}}, PROD_W'(span) * PROD_W'(tol)};
    reached = (lhs <= rhs);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Parameter limiting

  logic [FREQ_W-1:0] thresh_lim;
  logic [TOL_W-1:0]  tol_lim;
  logic [FREQ_W:0]   release_sum;

  // Clamp threshold and tolerance to allowed range
  assign thresh_lim = (thresh_i > THRESH_MAX) ? THRESH_MAX
                                              : thresh_i;
  assign tol_lim    = (tol_i < TOL_MIN) ? TOL_MIN :
                      (tol_i > TOL_MAX) ? TOL_MAX : tol_i;

  // freq < thresh - delta, as freq + delta < thresh (no underflow)
  assign release_sum = {1'b0, stator_freq_i} + {1'b0, delta_i};

  ////////////////////////////////////////////////////////////////////////
  // Threshold message with hysteresis

  logic thresh_q;
  logic thresh_d;
  logic set_cond;
  logic clr_cond;

  assign set_cond = stator_freq_i > thresh_lim;
  // Delta above threshold can never satisfy the release
  assign clr_cond = release_sum < {1'b0, thresh_lim};
  assign thresh_d = set_cond ? 1'b1 : (clr_cond ? 1'b0 : thresh_q);

  // Hysteresis state
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      thresh_q <= 1'b0;
    else
      thresh_q <= thresh_d;
  end

  ////////////////////////////////////////////////////////////////////////
  // Reference reached messages

  logic freq_ref_q;
  logic pct_ref_q;

  // Tolerance band checks, registered
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      freq_ref_q <= 1'b0;
      pct_ref_q  <= 1'b0;
    end
    else
    begin
      freq_ref_q <= reached(stator_freq_i, ref_freq_i, freq_max_i,
                            freq_min_i, tol_lim);
      pct_ref_q  <= reached(act_pct_i, ref_pct_i, pct_max_i,
                            pct_min_i, tol_lim);
    end
  end

  assign msg.thresh   = thresh_q;
  assign msg.freq_ref = freq_ref_q;
  assign msg.pct_ref  = pct_ref_q;

  ////////////////////////////////////////////////////////////////////////
  // Output selectors

  logic [SEL_W-1:0] sel_arr [NUM_OUT];
  assign sel_arr[0] = first_sel_i;
  assign sel_arr[1] = relay_sel_i;
  assign sel_arr[2] = terminal_sel_i;
  assign sel_arr[3] = multi_sel_i;

  // One selector per physical output
  for (genvar i = 0; i < NUM_OUT; i++)
  begin : g_sel
    omc_selector u_sel (
      .mclk_i     (mclk_i),
      .rst_i      (rst_i),
      .sel_i      (sel_arr[i]),
      .peer_i     (msg.out_msg),
      .thresh_i   (msg.thresh),
      .freq_ref_i (msg.freq_ref),
      .pct_ref_i  (msg.pct_ref),
      .out_o      (msg.out_msg[i])
    );
  end

  assign first_switch_output_o         = msg.out_msg[0];
  assign relay_switch_output_o         = msg.out_msg[1];
  assign terminal_switch_output_o      = msg.out_msg[2];
  assign multifunction_switch_output_o = msg.out_msg[3];
  assign thresh_msg_o   = thresh_q;
  assign freq_ref_msg_o = freq_ref_q;
  assign pct_ref_msg_o  = pct_ref_q;

  ////////////////////////////////////////////////////////////////////////
  // Signal source lookup

  logic src_d;
  logic src_q;

  // Source number to message
  assign src_d = (src_query_i == SRC_FIRST)    ? msg.out_msg[0] :
                 (src_query_i == SRC_RELAY)    ? msg.out_msg[1] :
                 (src_query_i == SRC_TERMINAL) ? msg.out_msg[2] :
                 (src_query_i == SRC_MULTI)    ? msg.out_msg[3] :
                 (src_query_i == SRC_THRESH)   ? thresh_q :
                 (src_query_i == SRC_FREQ_REF) ? freq_ref_q :
                 (src_query_i == SRC_PCT_REF)  ? pct_ref_q : 1'b0;

  // Registered source value
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      src_q <= 1'b0;
    else
      src_q <= src_d;
  end

  assign src_value_o = src_q;
endmodule
`default_nettype wire

//--- design/omc_msg_if.sv
`default_nettype none
// Function messages shared between evaluation and output selection
interface omc_msg_if;
  import omc_pkg::*;
  logic                    thresh;
  logic                    freq_ref;
  logic                    pct_ref;
  logic [NUM_OUT-1:0]      out_msg;
  modport source (output thresh, output freq_ref, output pct_ref,
                  input out_msg);
  modport sink   (input thresh, input freq_ref, input pct_ref,
                  output out_msg);
endinterface
`default_nettype wire

//--- design/omc_pkg.sv
`default_nettype none
package omc_pkg;
  // Selector field and frequency scaling (0.01 Hz per LSB)
  localparam int SEL_W  = 8;
  localparam int FREQ_W = 16;
  // Tolerance band, 0.01 % per LSB
  localparam int TOL_W  = 11;
  localparam int PROD_W = FREQ_W + TOL_W;
  localparam logic [PROD_W-1:0] TOL_FULL_SCALE = 27'h0002710; // 100.00 %
  localparam int NUM_OUT = 4;

  // Selector codes
  localparam logic [SEL_W-1:0] SEL_THRESH   = 8'h04;
  localparam logic [SEL_W-1:0] SEL_FREQ_REF = 8'h05;
  localparam logic [SEL_W-1:0] SEL_PCT_REF  = 8'h06;
  localparam logic [SEL_W-1:0] SEL_INV_BASE = 8'h64; // 100
  localparam logic [SEL_W-1:0] SEL_INV_LAST = 8'hC2; // 194

  // Internal signal source numbers, one per output and one per function message
  localparam logic [SEL_W-1:0] SRC_FIRST    = 8'hAF; // 175
  localparam logic [SEL_W-1:0] SRC_RELAY    = 8'hB0; // 176
  localparam logic [SEL_W-1:0] SRC_TERMINAL = 8'hB1; // 177
  localparam logic [SEL_W-1:0] SRC_MULTI    = 8'hB5; // 181
  localparam logic [SEL_W-1:0] SRC_FREQ_REF = 8'hA3; // 163
  localparam logic [SEL_W-1:0] SRC_THRESH   = 8'hA4; // 164
  localparam logic [SEL_W-1:0] SRC_PCT_REF  = 8'hB2; // 178

  // Parameter limits and defaults
  localparam logic [FREQ_W-1:0] THRESH_MAX     = 16'hE9FC; // 599.00 Hz
  localparam logic [FREQ_W-1:0] THRESH_DEFAULT = 16'h012C; // 3.00 Hz
  localparam logic [FREQ_W-1:0] DELTA_DEFAULT  = 16'h00C8; // 2.00 Hz
  localparam logic [TOL_W-1:0]  TOL_MIN        = 11'h001;  // 0.01 %
  localparam logic [TOL_W-1:0]  TOL_MAX        = 11'h7D0;  // 20.00 %
  localparam logic [TOL_W-1:0]  TOL_DEFAULT    = 11'h1F4;  // 5.00 %
endpackage
`default_nettype wire

//--- design/omc_selector.sv
`default_nettype none
// Routes a chosen function message to one output, with inversion
module omc_selector
  import omc_pkg::*;
(
  input  wire logic                          mclk_i,
  input  wire logic                          rst_i,
  input  wire logic [omc_pkg::SEL_W-1:0]     sel_i,
  input  wire logic [omc_pkg::NUM_OUT-1:0]   peer_i,
  input  wire logic                          thresh_i,
  input  wire logic                          freq_ref_i,
  input  wire logic                          pct_ref_i,
  output logic                               out_o
);
  logic             inv;
  logic [SEL_W-1:0] base;
  logic             msg;
  logic             out_d;
  logic             out_q;

  // Inverted range maps onto base code
  assign inv  = (sel_i >= SEL_INV_BASE) && (sel_i <= SEL_INV_LAST);
  assign base = inv ? sel_i - SEL_INV_BASE : sel_i;

  // Function lookup for the base code
  always_comb
  begin
    case (base)
      SEL_THRESH:   msg = thresh_i;
      SEL_FREQ_REF: msg = freq_ref_i;
      SEL_PCT_REF:  msg = pct_ref_i;
      default:      msg = 1'b0;
    endcase
  end

  assign out_d = msg ^ inv;

  // Registered output
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      out_q <= 1'b0;
    else
      out_q <= out_d;
  end

  assign out_o = out_q;
  logic unused_peer;
  assign unused_peer = ^peer_i;
endmodule
`default_nettype wire

//--- sim/omc_comparator_checker.sv
`default_nettype none
module omc_comparator_checker
  import omc_pkg::*;
(
  input wire logic                       mclk_i,
  input wire logic                       rst_i,
  input wire logic [omc_pkg::FREQ_W-1:0] stator_freq_i,
  input wire logic [omc_pkg::FREQ_W-1:0] thresh_i,
  input wire logic [omc_pkg::FREQ_W-1:0] delta_i,
  input wire logic [omc_pkg::SEL_W-1:0]  first_sel_i,
  input wire logic [omc_pkg::SEL_W-1:0]  relay_sel_i,
  input wire logic [omc_pkg::SEL_W-1:0]  multi_sel_i,
  input wire logic [omc_pkg::SEL_W-1:0]  src_query_i,
  input wire logic                       src_value_o,
  input wire logic                       thresh_msg_o,
  input wire logic                       freq_ref_msg_o,
  input wire logic                       first_switch_output_o,
  input wire logic                       relay_switch_output_o,
  input wire logic                       multifunction_switch_output_o
);
  logic [FREQ_W-1:0] thr_c;
  // Threshold as clamped by the design
  assign thr_c = (thresh_i > THRESH_MAX) ? THRESH_MAX : thresh_i;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  // Selector 4 held while above threshold
  sequence s_walk;
    first_sel_i == SEL_THRESH && stator_freq_i > thr_c
      ##1 first_sel_i == SEL_THRESH;
  endsequence
  a_thresh_set: assert property (
    stator_freq_i > thr_c |=> thresh_msg_o) else $error("no set");
  a_thresh_clear: assert property (
    stator_freq_i <= thr_c && ({1'b0, stator_freq_i} + delta_i) < thr_c
    |=> !thresh_msg_o) else $error("no clear");
  a_thresh_hold: assert property (
    stator_freq_i <= thr_c && ({1'b0, stator_freq_i} + delta_i) >= thr_c
    |=> $stable(thresh_msg_o)) else $error("no hold");
  a_walk_code4: assert property (
    s_walk |=> first_switch_output_o) else $error("walk");
  a_relay_inv5: assert property (
    relay_sel_i == SEL_INV_BASE + SEL_FREQ_REF
    |=> relay_switch_output_o == !$past(freq_ref_msg_o)) else $error("inv");
  a_multi_unused: assert property (
    multi_sel_i < SEL_THRESH |=> !multifunction_switch_output_o)
    else $error("unused");
  a_src_thresh: assert property (
    src_query_i == SRC_THRESH |=> src_value_o == $past(thresh_msg_o))
    else $error("src 164");
  a_src_freq: assert property (
    src_query_i == SRC_FREQ_REF |=> src_value_o == $past(freq_ref_msg_o))
    else $error("src 163");
endmodule
bind omc_comparator omc_comparator_checker omc_comparator_checker_inst (
  .mclk_i, .rst_i, .stator_freq_i, .thresh_i, .delta_i, .first_sel_i,
  .relay_sel_i, .multi_sel_i, .src_query_i, .src_value_o, .thresh_msg_o,
  .freq_ref_msg_o, .first_switch_output_o, .relay_switch_output_o,
  .multifunction_switch_output_o);
`default_nettype wire

//--- sim/omc_load_model.sv
`default_nettype none
// Equipment wired to the four switch outputs
module omc_load_model
(
  input  wire logic [3:0] drive_i,
  output logic      [3:0] seen_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // Pins sensed as driven
  assign seen_o = drive_i;
endmodule
`default_nettype wire

//--- sim/testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import omc_pkg::*;
  logic              mclk_i = 1'b0;
  logic              rst_i = 1'b1;
  logic [FREQ_W-1:0] stator_freq_i, ref_freq_i, freq_max_i, freq_min_i;
  logic [FREQ_W-1:0] act_pct_i, ref_pct_i, pct_max_i, pct_min_i;
  logic [FREQ_W-1:0] thresh_i, delta_i;
  logic [TOL_W-1:0]  tol_i;
  logic [SEL_W-1:0]  first_sel_i, relay_sel_i, terminal_sel_i, multi_sel_i;
  logic [SEL_W-1:0]  src_query_i;
  logic              src_value_o, thresh_msg_o, freq_ref_msg_o, pct_ref_msg_o;
  logic [3:0]        outs, seen;
  int                fails, samples_checked, m_t, m_f, m_p, m_s, th;
  int                m_o[4];
  logic [SEL_W-1:0]  codes[9] = '{8'h04, 8'h05, 8'h06, 8'h68, 8'h69, 8'h6A,
                                 8'h00, 8'h96, 8'h78};
  logic [SEL_W-1:0]  srcs[8] = '{8'hA4, 8'hA3, 8'hB2, 8'hAF, 8'hB0, 8'hB1,
                                8'hB5, 8'h00};
  // Clock
  always #2.5 mclk_i = ~mclk_i;
  omc_comparator omc_comparator_inst (
    .mclk_i, .rst_i, .stator_freq_i, .ref_freq_i, .freq_max_i, .freq_min_i,
    .act_pct_i, .ref_pct_i, .pct_max_i, .pct_min_i, .thresh_i, .delta_i,
    .tol_i, .first_sel_i, .relay_sel_i, .terminal_sel_i, .multi_sel_i,
    .src_query_i, .src_value_o, .thresh_msg_o, .freq_ref_msg_o,
    .pct_ref_msg_o, .first_switch_output_o(outs[0]),
    .relay_switch_output_o(outs[1]), .terminal_switch_output_o(outs[2]),
    .multifunction_switch_output_o(outs[3]));
  omc_load_model omc_load_model_inst (.drive_i(outs), .seen_o(seen));
  // Reached test within tolerance share of the span
  function automatic int hit(int a, int r, int hi, int lo, int t);
    int sp;
    sp = hi > lo ? hi - lo : 0;
    t = t < 1 ? 1 : t > 2000 ? 2000 : t;
    return (a > r ? a - r : r - a) * 10000 <= sp * t;
  endfunction
  // Selector decode with inversion band
  function automatic int pick(int s);
    int v, b;
    b = (s >= 100 && s <= 194) ? s - 100 : s;
    v = b == 4 ? m_t : b == 5 ? m_f : b == 6 ? m_p : 0;
    return s == b ? v : !v;
  endfunction
  // Reference model of the pipeline
  always @(posedge mclk_i or posedge rst_i)
    if (rst_i)
    begin
      {m_t, m_f, m_p, m_s} = '0;
      m_o = '{4{0}};
    end
    else
    begin
      case (src_query_i)
        8'hA4: m_s = m_t;
        8'hA3: m_s = m_f;
        8'hB2: m_s = m_p;
        8'hAF, 8'hB0, 8'hB1: m_s = m_o[src_query_i - 8'hAF];
        8'hB5: m_s = m_o[3];
        default: m_s = 0;
      endcase
      m_o = '{pick(first_sel_i), pick(relay_sel_i), pick(terminal_sel_i),
              pick(multi_sel_i)};
      th = thresh_i > 59900 ? 59900 : thresh_i;
      if (stator_freq_i > th)
        m_t = 1;
      else if (stator_freq_i + delta_i < th)
        m_t = 0;
      m_f = hit(stator_freq_i, ref_freq_i, freq_max_i, freq_min_i, tol_i);
      m_p = hit(act_pct_i, ref_pct_i, pct_max_i, pct_min_i, tol_i);
    end
  // Compare one function message
  task automatic chk_msg(string n, logic e, logic g);
    samples_checked++;
    if (g !== e)
    begin
      $display("CHECK FAILED %s exp %b got %b", n, e, g);
      fails++;
    end
  endtask
  // Compare one switch output as seen by the load
  task automatic chk_out(int i, logic e, logic g);
    samples_checked++;
    if (g !== e)
    begin
      $display("CHECK FAILED out%0d exp %b got %b", i, e, g);
      fails++;
    end
  endtask
  // Compare the looked-up signal source
  task automatic chk_src(logic e, logic g);
    samples_checked++;
    if (g !== e)
    begin
      $display("CHECK FAILED src exp %b got %b", e, g);
      fails++;
    end
  endtask
  // Compare every result mid-cycle
  always @(negedge mclk_i)
    if (!rst_i)
    begin
      chk_msg("thresh", m_t[0], thresh_msg_o);
      chk_msg("freq_ref", m_f[0], freq_ref_msg_o);
      chk_msg("pct_ref", m_p[0], pct_ref_msg_o);
      chk_src(m_s[0], src_value_o);
      foreach (m_o[i]) chk_out(i, m_o[i][0], seen[i]);
    end
  // Random inputs; cfg also sets limits and spans
  task automatic drive(int ph, bit cfg);
    int s;
    if (cfg)
    begin
      thresh_i = ph == 2 ? 16'hFFFF : ph == 3 ? 16'($urandom) : 16'h012C;
      delta_i = ph == 1 ? 16'h01F4 : ph[1] ? 16'($urandom) : 16'h00C8;
      tol_i = ph == 0 ? 11'h1F4 : ph == 1 ? 11'h000 : 11'($urandom);
      freq_max_i = ph == 3 ? 16'h015E : 16'h1388;
      freq_min_i = ph == 3 ? 16'h1388 : 16'h015E;
      pct_max_i = 16'($urandom);
      pct_min_i = 16'($urandom_range(0, 999));
    end
    s = $urandom_range(0, ph[1] ? 65535 : 800);
    stator_freq_i = 16'(s);
    ref_freq_i = 16'(s + $urandom_range(0, 600) - 300);
    act_pct_i = 16'($urandom);
    ref_pct_i = act_pct_i + 16'($urandom_range(0, 3000));
    first_sel_i = codes[$urandom_range(0, 8)];
    relay_sel_i = codes[$urandom_range(0, 8)];
    terminal_sel_i = codes[$urandom_range(0, 8)];
    multi_sel_i = codes[$urandom_range(0, 8)];
    src_query_i = srcs[$urandom_range(0, 7)];
  endtask
  task automatic summarize();
    if (fails == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Four phases: defaults, wide delta, clamps, random
  initial
  begin
    void'($urandom(32'h41AE));
    drive(0, 1'b1);
    repeat (16) @(posedge mclk_i);
    #1 rst_i = 1'b0;
    for (int ph = 0; ph < 4; ph++)
      for (int k = 0; k < 400; k++)
      begin
        drive(ph, k == 0);
        @(posedge mclk_i);
        #1;
      end
    summarize();
  end
endmodule
`default_nettype wire
